// File: rtl/status_pin_pkg.sv
package status_pin_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HSYNC_BEGIN_OFS = 8'h06;
  localparam logic [7:0] HSYNC_STOP_OFS = 8'h07;
  localparam logic [7:0] SYNC_CTRL_OFS = 8'h10;
  localparam logic [7:0] SWITCH_CTRL_OFS = 8'h11;
  localparam logic [7:0] PIN_SEL_OFS = 8'h12;
  localparam logic [7:0] OUT_CTRL_OFS = 8'h13;
  localparam logic [7:0] GATE_START_OFS = 8'h15;
  localparam logic [7:0] GATE_STOP_OFS = 8'h16;
  localparam logic [7:0] GATE_MSB_OFS = 8'h17;
  localparam logic [7:0] LINE_CTRL_FIRST_OFS = 8'h41;
  localparam logic [7:0] LINE_CTRL_LAST_OFS = 8'h57;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PIN_SEL_LSB = 4;
  localparam int CONVERTER_BYPASS_BIT = 1;
  localparam int HORIZ_LOCK_SPEED_BIT = 4;
  localparam int GENERAL_SWITCH_B_BIT = 7;
  localparam int HSYNC_FINE_DELAY_LSB = 4;
  localparam int VERT_REF_POSITION_BIT = 3;
  localparam int FIELD_ID_POLARITY_BIT = 3;
  localparam int GATE_START_MSB_BIT = 0;
  localparam int GATE_STOP_MSB_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_SEL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] HORIZ_REFERENCE_NORMAL_CYCLES = 12'd1440;
  localparam logic [3:0] RAW_DATA_TYPE = 4'h7;
  localparam int STEP8_SHIFT = 3;
  localparam int STEP2_SHIFT = 1;
  localparam logic [11:0] LINE_PERIOD_CYCLES = 12'd1728;

  typedef enum logic [3:0] {
    SEL_DOT_INPUT = 4'b0000,
    SEL_CONV_LSB = 4'b0001,
    SEL_SWITCH = 4'b0010,
    SEL_HLOCK = 4'b0011,
    SEL_BOTH_LOCK = 4'b0100,
    SEL_LOCK_COLOUR = 4'b0101,
    SEL_LINE_SEQ = 4'b0110,
    SEL_HORIZ_REFERENCE = 4'b0111,
    SEL_HSYNC = 4'b1000,
    SEL_GATED_HORIZ_REFERENCE = 4'b1001,
    SEL_ODD = 4'b1010,
    SEL_VSYNC = 4'b1011,
    SEL_VPULSE = 4'b1100,
    SEL_VERT_GATE_OUT = 4'b1101,
    SEL_VREF = 4'b1110,
    SEL_FIELD_ID = 4'b1111
  } pin_src_type;

  // Status and timing inputs from the decoder core
  typedef struct packed {
    logic horiz_lock_std;
    logic horiz_lock_fast;
    logic vert_lock;
    logic colour_detected;
    logic line_sequence_flag;
    logic converter_lsb;
    logic odd_field;
    logic vert_sync_out;
    logic vert_pulse_out;
    logic vert_ref_early;
    logic vert_ref_late;
    logic line_start;
    logic [8:0] line_number;
    logic [3:0] line_data_type;
  } core_status_type;

  // Register write port
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_type;

endpackage

// File: rtl/horiz_timing_gen.sv
`timescale 1ns/1ns
// Horizontal reference and sync pulse generator, counting from line start
module horiz_timing_gen (
  input wire logic i_sys_clk, // Line-locked clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic i_line_start, // One-cycle pulse at start of line
  input wire logic [3:0] i_data_type, // Data type of current line
  input wire logic [7:0] i_begin_value, // Pulse begin, 8-clock steps
  input wire logic [7:0] i_stop_value, // Pulse stop, 8-clock steps
  input wire logic [1:0] i_fine_delay, // Fine delay, 2-clock steps
  output logic o_horiz_reference, // Horizontal reference level
  output logic o_horiz_sync // Horizontal sync level
);

  logic [11:0] pos_r;
  logic [11:0] pos_nxt;
  logic horiz_reference_r;
  logic horiz_reference_nxt;
  logic hs_r;
  logic hs_nxt;
  logic [11:0] fine;
  logic [11:0] beg_pos;
  logic [11:0] end_pos;

  function automatic logic [11:0] step8(input logic [7:0] v, input logic [11:0] f);
    step8 = 12'({v, 3'b000}) + f;
  endfunction

  always_comb begin
    fine = 12'({i_fine_delay, 1'b0});
    beg_pos = step8(i_begin_value, fine);
    end_pos = step8(i_stop_value, fine);
    // Saturate so a missing line start never wraps back into the pulse window
    if (i_line_start) begin
      pos_nxt = 12'h000;
    end else if (&pos_r) begin
      pos_nxt = pos_r;
    end else begin
      pos_nxt = pos_r + 12'h001;
    end
    // raw lines use the programmable window, others the fixed width
    if (i_data_type == status_pin_pkg::RAW_DATA_TYPE) begin
      horiz_reference_nxt = (pos_nxt >= beg_pos) && (pos_nxt < end_pos);
    end else begin
      horiz_reference_nxt = pos_nxt < status_pin_pkg::HORIZ_REFERENCE_NORMAL_CYCLES;
    end
    hs_nxt = (pos_nxt >= beg_pos) && (pos_nxt < end_pos);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pos_r <= status_pin_pkg::LINE_PERIOD_CYCLES;
      horiz_reference_r <= 1'b0;
      hs_r <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      horiz_reference_r <= horiz_reference_nxt;
      hs_r <= hs_nxt;
    end
  end

  assign o_horiz_reference = horiz_reference_r;
  assign o_horiz_sync = hs_r;

endmodule

// File: rtl/vert_gate_gen.sv
`timescale 1ns/1ns
// Vertical gate and field identifier from programmable line numbers
module vert_gate_gen (
  input wire logic i_sys_clk, // Line-locked clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic [8:0] i_line_number, // Current line in field
  input wire logic [8:0] i_gate_start_line, // Gate start line
  input wire logic [8:0] i_gate_stop_line, // Gate stop line
  output logic o_vert_gate, // Vertical gate level
  output logic o_field_identifier // Field identifier, default polarity
);

  logic gate_r;
  logic gate_nxt;
  logic fid_r;
  logic fid_nxt;

  always_comb begin
    gate_nxt = gate_r;
    fid_nxt = fid_r;
    // rises at start line, falls at stop line
    if (i_line_number == i_gate_start_line) begin
      gate_nxt = 1'b1;
    end else if (i_line_number == i_gate_stop_line) begin
      gate_nxt = 1'b0;
    end
    // field identifier changes at the start line; line zero restarts it
    if (i_line_number == i_gate_start_line) begin
      fid_nxt = 1'b1;
    end else if (i_line_number == 9'h000) begin
      fid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      gate_r <= 1'b0;
      fid_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
      fid_r <= fid_nxt;
    end
  end

  assign o_vert_gate = gate_r;
  assign o_field_identifier = fid_r;

endmodule

// File: rtl/status_pin_source_select.sv
`timescale 1ns/1ns
// Functional notes
// - Selection is upper nibble of 0x12; code 0010 drives general switch bit 7 of 0x11.
// - Code 0000 floats the pin and uses it as the dot input.
// - Code 0001 outputs converter LSBs when bypass bit set; otherwise reserved.
// - Code 0011 outputs horizontal lock; 0x11 bit 4 picks standard or fast.
// - Code 0100 outputs vertical and horizontal lock together.
// - Code 0101 outputs both locks and colour detected.
// - Code 0110 outputs line-sequence flag, low on the DR line.
// - Code 0111 outputs horizontal reference, high while output data valid.
// - Horizontal reference width follows the current line's data type.
// - Data types other than 7 give 1440 cycles high.
// - Data type 7 uses programmable window in 8-clock steps plus fine delay.
// - Code 1000 outputs horizontal sync, width in 8-clock steps, 2-clock fine position.
// - Code 1001 outputs horizontal reference gated by vertical reference.
// - Code 1010 outputs odd/even field identifier, high on odd fields.
// - Code 1011 outputs vertical sync.
// - Code 1100 outputs vertical pulse.
// - Code 1101 outputs vertical gate from 9-bit start and stop lines.
// - Code 1110 outputs vertical reference at one of two positions.
// - Code 1111 outputs field identifier timed by gate start line.
// - Polarity bit 1 inverts field identifier, 0 keeps default.
module status_pin_source_select (
  input wire logic i_sys_clk, // Line-locked clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input status_pin_pkg::reg_wr_type i_reg_wr, // Register write from host
  input wire logic [7:0] i_rd_addr, // Register read address
  input status_pin_pkg::core_status_type i_core, // Decoder status inputs
  input wire logic i_status_pin_b_in, // Pad input level
  output logic o_status_pin_b_out, // Pad output level
  output logic o_status_pin_b_oe, // Pad output enable, high drives
  output logic o_dot_input, // Dot signal taken from the pad
  output logic [7:0] o_rd_data // Register read data
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] hsync_begin_r;
  logic [7:0] hsync_begin_nxt;
  logic [7:0] hsync_stop_r;
  logic [7:0] hsync_stop_nxt;
  logic [7:0] sync_ctrl_r;
  logic [7:0] sync_ctrl_nxt;
  logic [7:0] switch_ctrl_r;
  logic [7:0] switch_ctrl_nxt;
  logic [7:0] pin_sel_r;
  logic [7:0] pin_sel_nxt;
  logic [7:0] out_ctrl_r;
  logic [7:0] out_ctrl_nxt;
  logic [7:0] gate_start_r;
  logic [7:0] gate_start_nxt;
  logic [7:0] gate_stop_r;
  logic [7:0] gate_stop_nxt;
  logic [7:0] gate_msb_r;
  logic [7:0] gate_msb_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  function automatic logic [7:0] wr_update(
    input status_pin_pkg::reg_wr_type wr,
    input logic [7:0] ofs,
    input logic [7:0] cur
  );
    wr_update = (wr.wr_en && wr.addr == ofs) ? wr.data : cur;
  endfunction

  always_comb begin
    hsync_begin_nxt = wr_update(i_reg_wr, status_pin_pkg::HSYNC_BEGIN_OFS, hsync_begin_r);
    hsync_stop_nxt = wr_update(i_reg_wr, status_pin_pkg::HSYNC_STOP_OFS, hsync_stop_r);
    sync_ctrl_nxt = wr_update(i_reg_wr, status_pin_pkg::SYNC_CTRL_OFS, sync_ctrl_r);
    switch_ctrl_nxt = wr_update(i_reg_wr, status_pin_pkg::SWITCH_CTRL_OFS, switch_ctrl_r);
    pin_sel_nxt = wr_update(i_reg_wr, status_pin_pkg::PIN_SEL_OFS, pin_sel_r);
    out_ctrl_nxt = wr_update(i_reg_wr, status_pin_pkg::OUT_CTRL_OFS, out_ctrl_r);
    gate_start_nxt = wr_update(i_reg_wr, status_pin_pkg::GATE_START_OFS, gate_start_r);
    gate_stop_nxt = wr_update(i_reg_wr, status_pin_pkg::GATE_STOP_OFS, gate_stop_r);
    gate_msb_nxt = wr_update(i_reg_wr, status_pin_pkg::GATE_MSB_OFS, gate_msb_r);
    case (i_rd_addr)
      status_pin_pkg::HSYNC_BEGIN_OFS: rd_data_nxt = hsync_begin_r;
      status_pin_pkg::HSYNC_STOP_OFS: rd_data_nxt = hsync_stop_r;
      status_pin_pkg::SYNC_CTRL_OFS: rd_data_nxt = sync_ctrl_r;
      status_pin_pkg::SWITCH_CTRL_OFS: rd_data_nxt = switch_ctrl_r;
      status_pin_pkg::PIN_SEL_OFS: rd_data_nxt = pin_sel_r;
      status_pin_pkg::OUT_CTRL_OFS: rd_data_nxt = out_ctrl_r;
      status_pin_pkg::GATE_START_OFS: rd_data_nxt = gate_start_r;
      status_pin_pkg::GATE_STOP_OFS: rd_data_nxt = gate_stop_r;
      status_pin_pkg::GATE_MSB_OFS: rd_data_nxt = gate_msb_r;
      default: rd_data_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      hsync_begin_r <= status_pin_pkg::REG_RESET;
      hsync_stop_r <= status_pin_pkg::REG_RESET;
      sync_ctrl_r <= status_pin_pkg::REG_RESET;
      switch_ctrl_r <= status_pin_pkg::REG_RESET;
      pin_sel_r <= status_pin_pkg::PIN_SEL_RESET;
      out_ctrl_r <= status_pin_pkg::REG_RESET;
      gate_start_r <= status_pin_pkg::REG_RESET;
      gate_stop_r <= status_pin_pkg::REG_RESET;
      gate_msb_r <= status_pin_pkg::REG_RESET;
      rd_data_r <= 8'h00;
    end else begin
      hsync_begin_r <= hsync_begin_nxt;
      hsync_stop_r <= hsync_stop_nxt;
      sync_ctrl_r <= sync_ctrl_nxt;
      switch_ctrl_r <= switch_ctrl_nxt;
      pin_sel_r <= pin_sel_nxt;
      out_ctrl_r <= out_ctrl_nxt;
      gate_start_r <= gate_start_nxt;
      gate_stop_r <= gate_stop_nxt;
      gate_msb_r <= gate_msb_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  status_pin_pkg::pin_src_type pin_b_sel;
  logic converter_bypass;
  logic horiz_lock_speed_sel;
  logic general_switch_b;
  logic vert_ref_position;
  logic field_id_polarity;
  logic [1:0] hsync_fine_delay;
  logic [8:0] gate_start_line;
  logic [8:0] gate_stop_line;

  always_comb begin
    pin_b_sel = status_pin_pkg::pin_src_type'(pin_sel_r[status_pin_pkg::PIN_SEL_LSB +: 4]);
    converter_bypass = switch_ctrl_r[status_pin_pkg::CONVERTER_BYPASS_BIT];
    horiz_lock_speed_sel = switch_ctrl_r[status_pin_pkg::HORIZ_LOCK_SPEED_BIT];
    // Switch bit lives in the switch control register, not in the select nibble
    general_switch_b = switch_ctrl_r[status_pin_pkg::GENERAL_SWITCH_B_BIT];
    vert_ref_position = sync_ctrl_r[status_pin_pkg::VERT_REF_POSITION_BIT];
    field_id_polarity = out_ctrl_r[status_pin_pkg::FIELD_ID_POLARITY_BIT];
    hsync_fine_delay = sync_ctrl_r[status_pin_pkg::HSYNC_FINE_DELAY_LSB +: 2];
    gate_start_line = {gate_msb_r[status_pin_pkg::GATE_START_MSB_BIT], gate_start_r};
    gate_stop_line = {gate_msb_r[status_pin_pkg::GATE_STOP_MSB_BIT], gate_stop_r};
  end

  // ----------------------------------------------------------------
  // Source generators
  // ----------------------------------------------------------------
  logic horiz_reference;
  logic horiz_sync_out;
  logic vert_gate_out;
  logic field_identifier;

  horiz_timing_gen u_horiz (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_line_start(i_core.line_start),
    .i_data_type(i_core.line_data_type),
    .i_begin_value(hsync_begin_r),
    .i_stop_value(hsync_stop_r),
    .i_fine_delay(hsync_fine_delay),
    .o_horiz_reference(horiz_reference),
    .o_horiz_sync(horiz_sync_out)
  );

  vert_gate_gen u_vert (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_line_number(i_core.line_number),
    .i_gate_start_line(gate_start_line),
    .i_gate_stop_line(gate_stop_line),
    .o_vert_gate(vert_gate_out),
    .o_field_identifier(field_identifier)
  );

  // ----------------------------------------------------------------
  // Pin multiplexer
  // ----------------------------------------------------------------
  logic pin_out_r;
  logic pin_out_nxt;
  logic pin_oe_r;
  logic pin_oe_nxt;
  logic dot_r;
  logic dot_nxt;
  logic horiz_lock_flag;
  logic vert_ref;

  always_comb begin
    horiz_lock_flag = horiz_lock_speed_sel ? i_core.horiz_lock_fast
                                           : i_core.horiz_lock_std;
    vert_ref = vert_ref_position ? i_core.vert_ref_late : i_core.vert_ref_early;
    pin_out_nxt = 1'b0;
    pin_oe_nxt = 1'b1;
    dot_nxt = 1'b0;
    case (pin_b_sel)
      status_pin_pkg::SEL_DOT_INPUT: begin
        pin_oe_nxt = 1'b0;
        dot_nxt = i_status_pin_b_in;
      end
      // Reserved code without bypass: pin driven low rather than floating
      status_pin_pkg::SEL_CONV_LSB: pin_out_nxt = converter_bypass & i_core.converter_lsb;
      status_pin_pkg::SEL_SWITCH: pin_out_nxt = general_switch_b;
      status_pin_pkg::SEL_HLOCK: pin_out_nxt = horiz_lock_flag;
      status_pin_pkg::SEL_BOTH_LOCK: pin_out_nxt = i_core.vert_lock & i_core.horiz_lock_std;
      status_pin_pkg::SEL_LOCK_COLOUR: begin
        pin_out_nxt = i_core.vert_lock & i_core.horiz_lock_std & i_core.colour_detected;
      end
      status_pin_pkg::SEL_LINE_SEQ: pin_out_nxt = i_core.line_sequence_flag;
      status_pin_pkg::SEL_HORIZ_REFERENCE: pin_out_nxt = horiz_reference;
      status_pin_pkg::SEL_HSYNC: pin_out_nxt = horiz_sync_out;
      status_pin_pkg::SEL_GATED_HORIZ_REFERENCE: pin_out_nxt = horiz_reference & vert_ref;
      status_pin_pkg::SEL_ODD: pin_out_nxt = i_core.odd_field;
      status_pin_pkg::SEL_VSYNC: pin_out_nxt = i_core.vert_sync_out;
      status_pin_pkg::SEL_VPULSE: pin_out_nxt = i_core.vert_pulse_out;
      status_pin_pkg::SEL_VERT_GATE_OUT: pin_out_nxt = vert_gate_out;
      status_pin_pkg::SEL_VREF: pin_out_nxt = vert_ref;
      status_pin_pkg::SEL_FIELD_ID: pin_out_nxt = field_identifier ^ field_id_polarity;
      default: pin_out_nxt = 1'b0;
    endcase
  end

  // Registered so the pad only toggles on clock edges
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
      dot_r <= 1'b0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      dot_r <= dot_nxt;
    end
  end

  assign o_status_pin_b_out = pin_out_r;
  assign o_status_pin_b_oe = pin_oe_r;
  assign o_dot_input = dot_r;
  assign o_rd_data = rd_data_r;

endmodule

// File: sim/status_pin_chk.sv
`timescale 1ns/1ns
module status_pin_chk (
  input wire logic i_sys_clk, // Line-locked clock
  input wire logic i_reset_n, // Reset, active low
  input status_pin_pkg::reg_wr_type i_reg_wr, // Register write
  input wire logic [7:0] i_rd_addr, // Read address
  input status_pin_pkg::core_status_type i_core, // Decoder status
  input wire logic i_status_pin_b_in, // Pad input
  input wire logic o_status_pin_b_out, // Pad output
  input wire logic o_status_pin_b_oe, // Pad enable
  input wire logic o_dot_input, // Dot level
  input wire logic [7:0] o_rd_data // Read data
);
  // ----------------------------------------------------------------
  // Register mirrors and settle tracking
  // ----------------------------------------------------------------
  logic [7:0] sel_r, sel_nxt, ctl_r, ctl_nxt;
  logic [1:0] quiet_r, quiet_nxt;
  status_pin_pkg::core_status_type core_r;
  logic [3:0] code;
  logic calm;
  assign code = sel_r[7:4];
  // Only judge the mux once sources and registers have held long enough to pass both stages
  assign calm = quiet_r == 2'h3 && i_core == core_r && !i_reg_wr.wr_en;
  always_comb begin
    sel_nxt = sel_r;
    ctl_nxt = ctl_r;
    quiet_nxt = (quiet_r == 2'h3) ? quiet_r : quiet_r + 2'h1;
    if (i_reg_wr.wr_en || i_core != core_r) begin
      quiet_nxt = 2'h0;
    end
    if (i_reg_wr.wr_en && i_reg_wr.addr == status_pin_pkg::PIN_SEL_OFS) begin
      sel_nxt = i_reg_wr.data;
    end
    if (i_reg_wr.wr_en && i_reg_wr.addr == status_pin_pkg::SWITCH_CTRL_OFS) begin
      ctl_nxt = i_reg_wr.data;
    end
    if (!i_reset_n) begin
      sel_nxt = 8'h00;
      ctl_nxt = 8'h00;
      quiet_nxt = 2'h0;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    sel_r <= sel_nxt;
    ctl_r <= ctl_nxt;
    quiet_r <= quiet_nxt;
    core_r <= i_core;
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_float_zero: assert property (calm && code == 4'h0 |-> !o_status_pin_b_oe)
    else $error("pin driven while code zero");
  a_drive_set: assert property (calm && code != 4'h0 |-> o_status_pin_b_oe)
    else $error("pin floating while code set");
  a_select_latency: assert property (code == 4'h0 && $past(code) != 4'h0
    |-> o_status_pin_b_oe ##1 !o_status_pin_b_oe) else $error("select latency wrong");
  a_dot_follow: assert property (calm && code == 4'h0
    && $past(i_status_pin_b_in) == i_status_pin_b_in
    && $past(i_status_pin_b_in, 2) == i_status_pin_b_in
    |-> o_dot_input == i_status_pin_b_in) else $error("dot level not captured");
  a_dot_idle: assert property (calm && code != 4'h0 |-> !o_dot_input)
    else $error("dot level while driving");
  a_switch_level: assert property (calm && code == 4'h2 |-> o_status_pin_b_out == ctl_r[7])
    else $error("switch level wrong");
  a_conv_lsb: assert property (calm && code == 4'h1
    |-> o_status_pin_b_out == (ctl_r[1] & i_core.converter_lsb)) else $error("lsb wrong");
  a_hlock_speed: assert property (calm && code == 4'h3 |-> o_status_pin_b_out ==
    (ctl_r[4] ? i_core.horiz_lock_fast : i_core.horiz_lock_std)) else $error("lock wrong");
  a_lock_pair: assert property (calm && code == 4'h4
    |-> o_status_pin_b_out == (i_core.horiz_lock_std & i_core.vert_lock))
    else $error("loop lock flag wrong");
  a_lock_colour: assert property (calm && code == 4'h5 |-> o_status_pin_b_out ==
    (i_core.horiz_lock_std & i_core.vert_lock & i_core.colour_detected))
    else $error("colour lock flag wrong");
  a_line_seq: assert property (calm && code == 4'h6
    |-> o_status_pin_b_out == i_core.line_sequence_flag) else $error("sequence flag wrong");
  a_odd_field: assert property (calm && code == 4'ha
    |-> o_status_pin_b_out == i_core.odd_field) else $error("odd field wrong");
  a_vert_sync: assert property (calm && code == 4'hb
    |-> o_status_pin_b_out == i_core.vert_sync_out) else $error("vertical sync wrong");
  a_vert_pulse: assert property (calm && code == 4'hc
    |-> o_status_pin_b_out == i_core.vert_pulse_out) else $error("vertical pulse wrong");
  a_sel_readback: assert property (calm && $past(i_rd_addr) == 8'h12
    |-> o_rd_data == sel_r) else $error("select readback wrong");
  a_unmapped_zero: assert property ($past(i_rd_addr) == 8'h14 |-> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  c_horiz_reference_high: cover property (code == 4'h7 && o_status_pin_b_out);
  c_dot_high: cover property (code == 4'h0 && o_dot_input);
  c_fid_high: cover property (code == 4'hf && o_status_pin_b_out);
endmodule
bind status_pin_source_select status_pin_chk u_status_pin_chk (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_rd_addr(i_rd_addr),
  .i_core(i_core), .i_status_pin_b_in(i_status_pin_b_in),
  .o_status_pin_b_out(o_status_pin_b_out), .o_status_pin_b_oe(o_status_pin_b_oe),
  .o_dot_input(o_dot_input), .o_rd_data(o_rd_data));

// File: sim/capture_side_model.sv
`timescale 1ns/1ns
module capture_side_model (
  input wire logic i_sys_clk, // Line-locked clock
  input wire logic i_pin_out, // Pin level from the selector
  input wire logic i_pin_oe, // Pin enable from the selector
  input wire logic i_dot_level, // Dot source level while the pin floats
  input wire logic i_count_clr, // Clear the high counter
  output logic o_pad, // Resolved pad level
  output logic [11:0] o_high_count // Cycles the selector drove the pad high since clear
);
  // ----------------------------------------------------------------
  // Pad resolution and capture window counting
  // ----------------------------------------------------------------
  // The dot source only drives while the selector has let go of the pad
  assign o_pad = i_pin_oe ? i_pin_out : i_dot_level;
  always_ff @(posedge i_sys_clk) begin
    if (i_count_clr) begin
      o_high_count <= 12'h000;
    end else if (i_pin_oe && i_pin_out) begin
      o_high_count <= o_high_count + 12'h001;
    end
  end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------------------------------
  // Stimulus, tasks and sequence
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset_n, dot_level, count_clr, pad, pin_out, pin_oe, dot_in, e;
  status_pin_pkg::reg_wr_type reg_wr;
  status_pin_pkg::core_status_type core;
  logic [7:0] rd_addr, rd_data;
  logic [11:0] high_count;
  int fail_count = 0;
  int num_checks = 0;
  logic [7:0] regs [8] = '{8'h06, 8'h07, 8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h17};
  logic [7:0] vals [8] = '{8'h02, 8'h05, 8'h10, 8'h00, 8'h00, 8'h05, 8'h09, 8'h01};
  logic [3:0] codes [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hb, 4'hc};
  logic [3:0] types [4] = '{4'h0, 4'h6, 4'h8, 4'hf};
  always #10 sys_clk = ~sys_clk;
  status_pin_source_select u_status_pin_source_select (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_reg_wr(reg_wr), .i_rd_addr(rd_addr),
    .i_core(core), .i_status_pin_b_in(pad), .o_status_pin_b_out(pin_out),
    .o_status_pin_b_oe(pin_oe), .o_dot_input(dot_in), .o_rd_data(rd_data));
  capture_side_model u_capture_side_model (
    .i_sys_clk(sys_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_dot_level(dot_level),
    .i_count_clr(count_clr), .o_pad(pad), .o_high_count(high_count));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= '{1'b1, a, d};
    @(posedge sys_clk);
    reg_wr.wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    rd_addr <= a;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({4'h0, rd_data}, {4'h0, exp});
  endtask
  // At most two register stages sit between the pad and any source this task checks, so four edges is ample
  task automatic pin_is(input logic exp);
    repeat (4) @(posedge sys_clk);
    #1;
    chk({11'h000, pin_out}, {11'h000, exp});
  endtask
  task automatic set_pat(input logic [3:0] p);
    @(posedge sys_clk);
    core <= '{p[0], p[3], p[1], p[2], p[0], p[1], p[2], p[3], p[0] ^ p[1], 1'b0, 1'b0, 1'b0,
      9'h000, 4'h0};
  endtask
  task automatic at_line(input logic [8:0] n, input logic exp);
    @(posedge sys_clk);
    core.line_number <= n;
    pin_is(exp);
  endtask
  task automatic measure(input logic [3:0] dt, input logic [11:0] exp);
    @(posedge sys_clk);
    core.line_data_type <= dt;
    count_clr <= 1'b1;
    @(posedge sys_clk);
    count_clr <= 1'b0;
    core.line_start <= 1'b1;
    @(posedge sys_clk);
    core.line_start <= 1'b0;
    repeat (1700) @(posedge sys_clk);
    chk(high_count, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic exp_simple(input logic [3:0] c, input logic [3:0] p, input bit s);
    case (c)
      4'h1: return s & p[1];
      4'h2: return s;
      4'h3: return s ? p[3] : p[0];
      4'h4: return p[0] & p[1];
      4'h5: return p[0] & p[1] & p[2];
      4'h6: return p[0];
      4'ha: return p[2];
      4'hb: return p[3];
      default: return p[0] ^ p[1];
    endcase
  endfunction
  initial begin
    reset_n = 1'b0;
    reg_wr = '0;
    core = '0;
    rd_addr = 8'h00;
    dot_level = 1'b0;
    count_clr = 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h12, 8'h00);
    chk({11'h000, pin_oe}, 12'h000);
    rd(8'h14, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(regs[i], vals[i]);
      rd(regs[i], vals[i]);
    end
    // Fast lock is only chosen here because the bench source never jitters
    for (int s = 0; s < 2; s++) begin
      wr(8'h11, s[0] ? 8'h92 : 8'h00);
      for (int c = 0; c < 9; c++) begin
        wr(8'h12, {codes[c], 4'h0});
        for (int p = 0; p < 16; p++) begin
          set_pat(p[3:0]);
          e = exp_simple(codes[c], p[3:0], s[0]);
          pin_is(e);
        end
      end
    end
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    for (int d = 0; d < 2; d++) begin
      @(posedge sys_clk);
      dot_level <= ~d[0];
      repeat (4) @(posedge sys_clk);
      #1;
      chk({11'h000, dot_in}, {11'h000, ~d[0]});
      chk({11'h000, pin_oe}, 12'h000);
    end
    wr(8'h12, 8'h70);
    for (int t = 0; t < 4; t++) begin
      measure(types[t], 12'h5a0);
    end
    measure(4'h7, 12'h018);
    wr(8'h12, 8'h80);
    measure(4'h0, 12'h018);
    // Fine delay of one step moves the sync start from 16 to 18 clocks
    @(posedge sys_clk);
    core.line_start <= 1'b1;
    @(posedge sys_clk);
    core.line_start <= 1'b0;
    repeat (18) @(posedge sys_clk);
    #1;
    chk({11'h000, pin_out}, 12'h000);
    @(posedge sys_clk);
    #1;
    chk({11'h000, pin_out}, 12'h001);
    wr(8'h12, 8'h90);
    measure(4'h0, 12'h000);
    @(posedge sys_clk);
    core.vert_ref_early <= 1'b1;
    core.vert_ref_late <= 1'b1;
    measure(4'h0, 12'h5a0);
    wr(8'h12, 8'he0);
    @(posedge sys_clk);
    core.vert_ref_late <= 1'b0;
    pin_is(1'b1);
    wr(8'h10, 8'h18);
    pin_is(1'b0);
    wr(8'h12, 8'hd0);
    at_line(9'h009, 1'b0);
    at_line(9'h105, 1'b1);
    at_line(9'h050, 1'b1);
    at_line(9'h009, 1'b0);
    wr(8'h12, 8'hf0);
    at_line(9'h000, 1'b0);
    at_line(9'h105, 1'b1);
    at_line(9'h050, 1'b1);
    wr(8'h13, 8'h08);
    at_line(9'h050, 1'b0);
    at_line(9'h000, 1'b1);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h12, 8'h00);
    chk({11'h000, pin_oe}, 12'h000);
    give_verdict();
  end
endmodule
